// File: bopc_pkg.sv
package bopc_pkg;

  // Bytes of the command link
  localparam logic [7:0]  CH_CR     = 8'h0d;
  localparam logic [7:0]  CH_COMMA  = 8'h2c;
  localparam logic [7:0]  CH_MINUS  = 8'h2d;
  localparam logic [7:0]  CH_POINT  = 8'h2e;
  localparam logic [7:0]  CH_ZERO   = 8'h30;
  localparam logic [7:0]  CH_HASH   = 8'h23;
  // Cluster and axis selector letters
  localparam logic [7:0]  CH_GYRO   = 8'h67;
  localparam logic [7:0]  CH_ACC    = 8'h61;
  localparam logic [7:0]  CH_INC    = 8'h69;
  localparam logic [7:0]  CH_X      = 8'h78;
  localparam logic [7:0]  CH_Y      = 8'h79;
  localparam logic [7:0]  CH_Z      = 8'h7a;
  // Command name as received, reply name with separator
  localparam logic [39:0] CMD_NAME  = 40'h2473627 << 12 | 40'h46f;
  localparam logic [3:0]  CMD_LEN   = 4'h5;
  localparam logic [47:0] RPL_NAME  = 48'h23736274_6f2c;
  // Check value of every message
  localparam logic [7:0]  CRC_POLY  = 8'h07;
  localparam logic [7:0]  CRC_INIT  = 8'h00;
  // Execution status codes
  localparam logic [1:0]  ST_OK     = 2'h0;
  localparam logic [1:0]  ST_CRC    = 2'h1;
  localparam logic [1:0]  ST_SYNTAX = 2'h2;
  // Fractional digits printed per cluster
  localparam logic [2:0]  FD_GYRO   = 3'h5;
  localparam logic [2:0]  FD_ACC    = 3'h6;
  localparam logic [2:0]  FD_INC    = 3'h7;
  // Positions inside one printed number, last header position and last axis
  localparam logic [3:0]  NP_POINT  = 4'h4;
  localparam logic [3:0]  NP_FRAC   = 4'h5;
  localparam logic [3:0]  NP_COMMA  = 4'hc;
  localparam logic [3:0]  HDR_LAST  = 4'h7;
  localparam logic [3:0]  AXIS_LAST = 4'h8;

  typedef enum logic [4:0] {
    S_RX  = 5'b00001,
    S_HDR = 5'b00010,
    S_NUM = 5'b00100,
    S_CRC = 5'b01000,
    S_CR  = 5'b10000
  } bopc_state_t;

  typedef struct packed {
    bopc_state_t               state;   // Receive or reply phase
    logic [2:0]                fld;     // Commas seen
    logic [3:0]                len;     // Chars in current field
    logic [7:0]                crc;     // Running check value
    logic [7:0]                crc_snap; // Check value up to last comma
    logic                      bad;     // Syntax fault seen
    logic                      numbad;  // Current field not decimal
    logic                      neg;     // Value sign
    logic [1:0]                nint;    // Integer digits taken
    logic [2:0]                nfrac;   // Fraction digits taken
    logic                      in_frac; // Point seen
    logic [2:0][3:0]           vint;    // Value integer digits
    logic [6:0][3:0]           vfrac;   // Value fraction digits
    logic [9:0]                num;     // Current field as number
    logic [7:0]                first;   // First char of field
    logic [7:0]                clus;    // Cluster letter
    logic [7:0]                axis;    // Axis letter
    logic [8:0]                sgn;     // Offset signs
    logic [8:0][2:0][3:0]      oint;    // Offset integer digits
    logic [8:0][6:0][3:0]      ofrac;   // Offset fraction digits
    logic [1:0]                status;  // Status of last command
    logic [3:0]                k;       // Axis being printed
    logic [3:0]                p;       // Position in field
    logic [7:0]                obyte;   // Output byte register
    logic                      ovalid;  // Output byte pending
  } bopc_regs_t;

  // Whole state after reset: receiving, offsets zero, output empty
  localparam bopc_regs_t REGS_RST = '{state: S_RX, default: '0};

  // One byte of the bitwise CRC-8, MSB first
  function automatic logic [7:0] bopc_crc8(input logic [7:0] c,
                                           input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ CRC_POLY) : (x << 1);
    end
    return x;
  endfunction

endpackage

// File: bopc_sbto.sv
`timescale 1ns/100ps
module bopc_sbto
  import bopc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic [7:0]            rx_data,
  input  wire logic                  rx_valid,
  output logic                       rx_ready,
  output logic [7:0]                 tx_data,
  output logic                       tx_valid,
  input  wire logic                  tx_ready,
  output logic [8:0]                 off_sign,
  output logic [8:0][2:0][3:0]       off_int,
  output logic [8:0][6:0][3:0]       off_frac
);

  bopc_regs_t r;          // Present state
  bopc_regs_t n;          // Next state
  logic       take;       // Output register can load
  logic       emit;       // Generator has a byte this step
  logic [7:0] ch;         // Generated byte
  logic [3:0] d;          // Received byte as digit
  logic       isdig;      // Received byte is a digit
  logic [1:0] ci;         // Cluster index
  logic [1:0] ai;         // Axis index
  logic       clus_ok;    // Cluster letter legal
  logic       axis_ok;    // Axis letter legal
  logic [2:0] nfd;        // Fraction digits for axis k
  logic [7:0] ch_h;       // Reply check value hundreds
  logic [7:0] ch_t;       // Reply check value tens
  logic [7:0] ch_o;       // Reply check value ones
  logic       fin;        // Command line complete this cycle
  logic       apply;      // Offsets take the value
  logic [8:0] selm;       // Axes that take the value

  assign rx_ready = (r.state == S_RX);
  assign tx_valid = r.ovalid;
  assign tx_data  = r.obyte;
  assign off_sign = r.sgn;
  assign off_int  = r.oint;
  assign off_frac = r.ofrac;
  assign take     = !r.ovalid || tx_ready;
  assign fin      = rx_ready && rx_valid && (rx_data == CH_CR);

  // Selector decoding
  always_comb begin
    d       = rx_data[3:0];
    isdig   = (rx_data >= CH_ZERO) && (rx_data <= 8'h39);
    clus_ok = (r.clus == CH_GYRO) || (r.clus == CH_ACC) ||
              (r.clus == CH_INC);
    ci      = (r.clus == CH_GYRO) ? 2'h0 :
              (r.clus == CH_ACC)  ? 2'h1 : 2'h2;
    axis_ok = (r.axis == CH_X) || (r.axis == CH_Y) ||
              (r.axis == CH_Z);
    ai      = (r.axis == CH_X) ? 2'h0 :
              (r.axis == CH_Y) ? 2'h1 : 2'h2;
    for (int j = 0; j < 9; j++) begin
      if (r.fld == 3'h2) begin
        selm[j] = 1'b1;
      end else if (r.fld == 3'h3) begin
        selm[j] = (j / 3) == int'(ci);
      end else begin
        selm[j] = j == (int'(ci) * 3 + int'(ai));
      end
    end
    // Fraction width per cluster
    nfd = (r.k < 4'h3) ? FD_GYRO :
          (r.k < 4'h6) ? FD_ACC : FD_INC;
    ch_h = CH_ZERO + 8'(r.crc / 8'd100);
    ch_t = CH_ZERO + 8'((r.crc / 8'd10) % 8'd10);
    ch_o = CH_ZERO + 8'(r.crc % 8'd10);
  end

  // Reply byte generator
  always_comb begin
    emit = 1'b1;
    ch   = CH_COMMA;
    unique case (r.state)
      S_HDR: begin
        if (r.p < 4'h6) begin
          ch = RPL_NAME[8 * (5 - int'(r.p)) +: 8];
        end else if (r.p == 4'h6) begin
          ch = CH_ZERO + {6'h00, r.status};
        end
      end
      S_NUM: begin
        if (r.p == 4'h0) begin
          ch   = CH_MINUS;
          emit = r.sgn[r.k];
        end else if (r.p < NP_POINT) begin
          // Leading zeros dropped, units digit always shown
          ch   = CH_ZERO + {4'h0, r.oint[r.k][3 - int'(r.p)]};
          emit = (r.p == 4'h3) || (r.oint[r.k][2] != 4'h0) ||
                 (r.p == 4'h2 && r.oint[r.k][1] != 4'h0);
        end else if (r.p == NP_POINT) begin
          ch = CH_POINT;
        end else if (r.p < NP_COMMA) begin
          ch   = CH_ZERO + {4'h0, r.ofrac[r.k][11 - int'(r.p)]};
          emit = (r.p - NP_FRAC) < {1'b0, nfd};
        end
      end
      S_CRC: begin
        // Check value printed in decimal without leading zeros
        ch   = (r.p == 4'h0) ? ch_h : (r.p == 4'h1) ? ch_t : ch_o;
        emit = (r.p == 4'h2) || (ch_h != CH_ZERO) ||
               (r.p == 4'h1 && ch_t != CH_ZERO);
      end
      S_CR: begin
        ch = CH_CR;
      end
      S_RX: begin
        emit = 1'b0;
      end
    endcase
  end

  // Parser, offset store and reply sequencing
  always_comb begin
    n     = r;
    apply = 1'b0;
    if (r.ovalid && tx_ready) begin
      n.ovalid = 1'b0;
    end
    unique case (r.state)
      S_RX: begin
        if (rx_valid && rx_data == CH_CR) begin
          // Check value must match the bytes up to the last comma
          if (r.fld < 3'h2 || r.fld > 3'h4 || r.bad ||
              (r.fld >= 3'h3 && !clus_ok) ||
              (r.fld == 3'h4 && !axis_ok)) begin
            n.status = ST_SYNTAX;
          end else if (r.numbad || r.len == 4'h0 ||
                       r.num != {2'h0, r.crc_snap}) begin
            n.status = ST_CRC;
          end else begin
            n.status = ST_OK;
            apply    = 1'b1;
          end
          for (int j = 0; j < 9; j++) begin
            if (apply && selm[j]) begin
              n.sgn[j]   = r.neg;
              n.oint[j]  = r.vint;
              n.ofrac[j] = r.vfrac;
            end
          end
          n.state = S_HDR;
          n.crc   = CRC_INIT;
          n.p     = 4'h0;
          n.k     = 4'h0;
          {n.fld, n.len, n.bad, n.numbad, n.neg} = '0;
          {n.nint, n.nfrac, n.in_frac, n.vint, n.vfrac, n.num} = '0;
        end else if (rx_valid && rx_data == CH_COMMA) begin
          n.crc      = bopc_crc8(r.crc, rx_data);
          n.crc_snap = n.crc;
          unique case (r.fld)
            3'h0: n.bad = r.bad || (r.len != CMD_LEN);
            3'h1: n.bad = r.bad || (r.nint == 2'h0 && r.nfrac == 3'h0);
            3'h2: begin
              n.clus = r.first;
              n.bad  = r.bad || (r.len != 4'h1);
            end
            3'h3: begin
              n.axis = r.first;
              n.bad  = r.bad || (r.len != 4'h1);
            end
            default: n.bad = r.bad;
          endcase
          n.fld    = (r.fld == 3'h7) ? r.fld : r.fld + 3'h1;
          n.len    = 4'h0;
          n.num    = 10'h000;
          n.numbad = 1'b0;
        end else if (rx_valid) begin
          n.crc = bopc_crc8(r.crc, rx_data);
          n.len = (r.len == 4'hf) ? r.len : r.len + 4'h1;
          if (r.len == 4'h0) begin
            n.first = rx_data;
          end
          // Every field after the value may be the check value
          n.numbad = r.numbad || !isdig || (r.len >= 4'h3);
          n.num    = 10'({r.num, 3'h0} + {r.num, 1'h0} + {6'h00, d});
          if (r.fld == 3'h0) begin
            n.bad = r.bad || (r.len >= CMD_LEN) ||
                    (rx_data != CMD_NAME[8 * (4 - int'(r.len)) +: 8]);
          end else if (r.fld == 3'h1) begin
            if (rx_data == CH_MINUS && r.len == 4'h0) begin
              n.neg = 1'b1;
            end else if (rx_data == CH_POINT && !r.in_frac) begin
              n.in_frac = 1'b1;
            end else if (isdig && r.in_frac) begin
              // Digits past seven are truncated
              if (r.nfrac != 3'h7) begin
                n.vfrac[6 - int'(r.nfrac)] = d;
                n.nfrac = r.nfrac + 3'h1;
              end
            end else if (isdig && r.nint != 2'h3) begin
              n.vint = {r.vint[1:0], d};
              n.nint = r.nint + 2'h1;
            end else begin
              n.bad = 1'b1;
            end
          end
        end
      end
      S_HDR, S_NUM, S_CRC, S_CR: begin
        if (!emit || take) begin
          if (emit) begin
            n.obyte  = ch;
            n.ovalid = 1'b1;
            if (r.state == S_HDR || r.state == S_NUM) begin
              n.crc = bopc_crc8(r.crc, ch);
            end
          end
          n.p = r.p + 4'h1;
          if (r.state == S_HDR && r.p == HDR_LAST) begin
            n.state = S_NUM;
            n.p     = 4'h0;
          end else if (r.state == S_NUM && r.p == NP_COMMA) begin
            n.p = 4'h0;
            n.k = r.k + 4'h1;
            if (r.k == AXIS_LAST) begin
              n.state = S_CRC;
            end
          end else if (r.state == S_CRC && r.p == 4'h2) begin
            n.state = S_CR;
          end else if (r.state == S_CR) begin
            // Next command's check value must not inherit the reply's
            n.state = S_RX;
            n.crc   = CRC_INIT;
          end
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= REGS_RST;
    end else begin
      r <= n;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Helpers watched by the checks
  logic       loading;    // Byte enters output register
  logic [8:0] chg;        // Offsets that change this cycle
  assign loading = (r.state != S_RX) && emit && take;
  always_comb begin
    for (int j = 0; j < 9; j++) begin
      chg[j] = (n.sgn[j] != r.sgn[j]) || (n.oint[j] != r.oint[j]) ||
               (n.ofrac[j] != r.ofrac[j]);
    end
  end

  sequence seq_cmd_end;
    fin && r.fld == 3'h4 && n.status == ST_OK;
  endsequence
  sequence seq_reply_open;
    r.state == S_HDR && r.p == 4'h0 && loading;
  endsequence

  AST_ONE_AXIS: assert property (seq_cmd_end |->
    (chg & ~selm) == 9'h000 && $onehot(selm)) else $error("Other axes");
  AST_ZERO_ALL: assert property (fin && r.fld == 3'h2
    && n.status == ST_OK && !r.neg && r.vint == '0 && r.vfrac == '0 |=>
    r.oint == '0 && r.ofrac == '0 && r.sgn == 9'h000) else $error("Zero");
  AST_GYRO_FRAC: assert property (r.state == S_NUM && r.k < 4'h3
    && loading |-> r.p < 4'ha || r.p == NP_COMMA) else $error("Gyro");
  AST_ACC_FRAC: assert property (r.state == S_NUM && r.k > 4'h2
    && r.k < 4'h6 && loading |-> r.p != 4'hb) else $error("Acc digits");
  AST_INC_FRAC: assert property (r.state == S_NUM && r.k > 4'h5
    && r.p == 4'hb |-> emit) else $error("Inc digits");
  AST_REPLY_HEAD: assert property (seq_reply_open |->
    ch == CH_HASH ##[1:20] (r.state == S_HDR && r.p == 4'h6 && loading
    && ch == CH_ZERO + {6'h00, r.status})) else $error("Bad head");
  AST_CLUSTER: assert property (fin && r.fld >= 3'h3 && !clus_ok
    |=> r.status == ST_SYNTAX) else $error("Bad cluster kept");
  AST_AXIS: assert property (fin && r.fld == 3'h4 && !axis_ok
    |=> r.status == ST_SYNTAX) else $error("Bad axis kept");
  AST_CRC_REJECT: assert property (fin && n.status == ST_CRC |->
    chg == 9'h000 ##1 r.state == S_HDR) else $error("Crc fault");
  AST_REPLY_END: assert property (r.state == S_CR && take |=>
    r.obyte == CH_CR && r.ovalid && r.state == S_RX) else $error("No CR");

endmodule

// File: bopc_host.sv
`timescale 1ns/100ps
// Host model: sends command lines and sinks the reply
module bopc_host (
  input  wire logic       clk,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  string      rep;    // Reply bytes collected
  logic       got_cr; // Reply end seen
  logic       slow;   // Stall the reply side
  logic [1:0] cnt;    // Stall pattern counter

  // Quiet lines at time zero
  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
    rep      = "";
    got_cr   = 1'b0;
    slow     = 1'b0;
    cnt      = 2'h0;
  end

  // Check value, poly 0x07, init 0x00, MSB first
  function automatic logic [7:0] crc_str(string s);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < s.len(); i++) begin
      c = c ^ s[i];
      for (int b = 0; b < 8; b++) begin
        c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
      end
    end
    return c;
  endfunction

  // Offer one byte, hold it until the edge that takes it
  task automatic put(input logic [7:0] b);
    bit r;
    rx_valid <= 1'b1;
    rx_data  <= b;
    for (int n = 0; n < 4000; n++) begin
      @(negedge clk);
      r = rx_ready;
      @(posedge clk);
      if (r) begin
        return;
      end
    end
    tb.fails++;
    tb.test_done();
  endtask

  // Body, comma, decimal check value, CR; bad spoils the check
  task automatic send(input string body, input bit bad);
    string      s;
    logic [7:0] v;
    s = {body, ","};
    v = crc_str(s) + {7'h00, bad};
    s = {s, $sformatf("%0d", v)};
    rep    = "";
    got_cr = 1'b0;
    @(posedge clk);
    for (int i = 0; i < s.len(); i++) begin
      put(s[i]);
    end
    put(8'h0d);
    rx_valid <= 1'b0;
    // Released data line must not keep the last byte
    rx_data  <= ~rx_data;
  endtask

  // Reply sink; slow mode refuses one cycle in four
  always @(posedge clk) begin
    cnt      <= cnt + 2'h1;
    tx_ready <= !slow || (cnt != 2'h0);
    if (tx_valid && tx_ready) begin
      rep = {rep, $sformatf("%c", tx_data)};
      if (tx_data == 8'h0d) begin
        got_cr = 1'b1;
      end
    end
  end
endmodule

// File: tb.sv
`timescale 1ns/100ps
// Bench for the offset command block
module tb;
  logic                  clk;      // 125 MHz clock
  logic                  sys_rst;  // Synchronous reset
  logic [7:0]            rx_data;  // Command byte
  logic                  rx_valid; // Command byte offered
  logic                  rx_ready; // Block accepts
  logic [7:0]            tx_data;  // Reply byte
  logic                  tx_valid; // Reply byte offered
  logic                  tx_ready; // Host accepts
  logic [8:0]            off_sign; // Offset signs
  logic [8:0][2:0][3:0]  off_int;  // Integer digits
  logic [8:0][6:0][3:0]  off_frac; // Fraction digits
  int                    fails;    // Mismatches
  int                    n_tests;  // Comparisons
  int unsigned           mag [9];  // Expected magnitude, 1e-7 units
  bit                    neg [9];  // Expected sign

  bopc_sbto dut (.clk(clk), .sys_rst(sys_rst), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .off_sign(off_sign),
    .off_int(off_int), .off_frac(off_frac));

  bopc_host host (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready));

  // Clock, 8 ns period
  initial clk = 1'b0;
  always #4 clk = ~clk;

  // Verdict and end of run
  task automatic test_done();
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compare reply text
  task automatic cmp_s(input string got, input string exp);
    n_tests++;
    if (got != exp) begin
      fails++;
      $display("ERROR %0t reply %s expected %s", $time, got, exp);
    end
  endtask

  // Compare port value
  task automatic cmp_v(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t port %h expected %h", $time, got, exp);
    end
  endtask

  // One offset as printed; decimals depend on the cluster
  function automatic string fmt(input int j);
    int unsigned ip;
    int unsigned fr;
    string       s;
    ip = mag[j] / 10000000;
    fr = mag[j] % 10000000;
    if (j < 3) begin
      s = $sformatf("%0d.%05d", ip, fr / 100);
    end else if (j < 6) begin
      s = $sformatf("%0d.%06d", ip, fr / 10);
    end else begin
      s = $sformatf("%0d.%07d", ip, fr);
    end
    return neg[j] ? {"-", s} : s;
  endfunction

  // Send a line, wait for the whole reply, judge it
  task automatic run(input string body, input bit bad, input int st);
    string e;
    host.send(body, bad);
    for (int n = 0; n < 4000 && !host.got_cr; n++) begin
      @(negedge clk);
    end
    if (!host.got_cr) begin
      fails++;
      $display("ERROR %0t no reply", $time);
      test_done();
    end
    e = $sformatf("#sbto,%0d,", st);
    for (int j = 0; j < 9; j++) begin
      e = {e, fmt(j), ","};
    end
    e = {e, $sformatf("%0d", host.crc_str(e)), "\015"};
    cmp_s(host.rep, e);
  endtask

  // Value without selectors reaches all nine axes
  task automatic s_all();
    for (int j = 0; j < 9; j++) begin
      mag[j] = 15000000;
      neg[j] = 1'b0;
    end
    run("$sbto,1.5", 1'b0, 0);
  endtask

  // One axis of one cluster, negative value
  task automatic s_axis();
    mag[1] = 34000;
    neg[1] = 1'b1;
    run("$sbto,-0.0034,g,y", 1'b0, 0);
    cmp_v({55'h0, off_sign}, 64'h002);
    cmp_v({24'h0, off_int[1], off_frac[1]}, 64'h0034000);
  endtask

  // Every cluster and axis letter once, then a bad letter of each kind
  task automatic s_sel();
    string cl;
    string ax;
    string b;
    cl = "gai";
    ax = "xyz";
    for (int i = 0; i < 3; i++) begin
      mag[i * 4] = (i + 3) * 10000000;
      b = $sformatf("$sbto,%0d,%c,%c", i + 3, cl[i], ax[i]);
      run(b, 1'b0, 0);
    end
    run("$sbto,5,q", 1'b0, 2);
    run("$sbto,5,g,w", 1'b0, 2);
  endtask

  // Cluster only; two integer digits, no leading zero printed
  task automatic s_clus();
    for (int j = 3; j < 6; j++) begin
      mag[j] = 125000000;
      neg[j] = 1'b0;
    end
    run("$sbto,12.5,a", 1'b0, 0);
  endtask

  // Spoiled check value refused, host stalling the reply
  task automatic s_badcrc();
    host.slow = 1'b1;
    run("$sbto,7", 1'b1, 1);
    host.slow = 1'b0;
  endtask

  // Bare zero clears every offset
  task automatic s_zero();
    for (int j = 0; j < 9; j++) begin
      mag[j] = 0;
      neg[j] = 1'b0;
    end
    run("$sbto,0", 1'b0, 0);
    cmp_v({55'h0, off_sign}, 64'h0);
  endtask

  // Main sequence
  initial begin
    fails   = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    s_all();
    s_axis();
    s_sel();
    s_clus();
    s_badcrc();
    s_zero();
    test_done();
  end
endmodule
